/* core/fbs_params.svh */
// Purpose: constants of the flash boot swap and shield window block
// Assumes: 20-bit array address, 1 KB blocks, 64 blocks, 4 KB boot clusters
// Notes: offsets, field positions, window and swap reset values live here; other widths and reset values are written out in the code
`ifndef FBS_PARAMS_SVH
`define FBS_PARAMS_SVH
`define FBS_ADDR_W 20
`define FBS_BLK_W 6
`define FBS_BLK_LSB 10
`define FBS_BLK_MSB 15
`define FBS_CLUS_BIT 12
`define FBS_SWAP_TOP_LSB 13
`define FBS_SWAP_TOP_ZERO 7'h00
`define FBS_BC0_LO 20'h00000
`define FBS_BC0_HI 20'h00fff
`define FBS_BLK_UPPER_ZERO 4'h0
`define FBS_WIN_START_RST 6'h00
`define FBS_WIN_END_RST 6'h3f
`define FBS_SWAP_RST 1'h0
`endif

/* core/fbs_pkg.sv */
// Purpose: types shared by the flash boot swap and shield window block
// Assumes: nothing beyond the params header
// Notes: states are one-hot
package fbs_pkg;
	typedef enum logic [0:0] {
		FBS_OP_ERASE = 1'h0,
		FBS_OP_WRITE = 1'h1
	} fbs_op_t;
	typedef enum logic [1:0] {
		FBS_ST_LOAD = 2'h1,
		FBS_ST_RUN = 2'h2
	} fbs_state_t;
endpackage : fbs_pkg

/* core/fbs_chk_if.sv */
// Purpose: carries one access check between the top and the checker
// Assumes: single clock, checker is purely combinational
// Notes: req side drives the question, chk side drives the verdict
`timescale 1ns/10ps
interface fbs_chk_if;
	logic [19:0] addr;
	logic mode_self;
	logic mode_ext;
	logic bc0_protect;
	logic [5:0] win_start;
	logic [5:0] win_end;
	logic in_window;
	logic bc0_hit;
	logic allow;
	modport req (output addr, output mode_self, output mode_ext, output bc0_protect,
		output win_start, output win_end, input in_window, input bc0_hit, input allow);
	modport chk (input addr, input mode_self, input mode_ext, input bc0_protect,
		input win_start, input win_end, output in_window, output bc0_hit, output allow);
endinterface : fbs_chk_if

/* core/fbs_access_check.sv */
// Purpose: decides whether one erase or write address may be touched
// Assumes: address already translated through the boot swap
// Notes: purely combinational; the top registers the verdict
`timescale 1ns/10ps
`include "fbs_params.svh"
module fbs_access_check (
	fbs_chk_if.chk ch
);
	logic [5:0] blk;
	logic upper_clear;

	// block index of the address; blocks above the 64 KB array never match
	assign blk = ch.addr[`FBS_BLK_MSB:`FBS_BLK_LSB];
	assign upper_clear = (ch.addr[`FBS_ADDR_W-1:`FBS_BLK_MSB+1] == `FBS_BLK_UPPER_ZERO);

	// inclusive range; start above end gives an empty window
	assign ch.in_window = upper_clear && (blk >= ch.win_start) && (blk <= ch.win_end);

	// cluster 0 protection window
	assign ch.bc0_hit = ch.bc0_protect && (ch.addr >= `FBS_BC0_LO) && (ch.addr <= `FBS_BC0_HI);

	// protection first, then the mode: external ignores the window, self keeps to it
	always_comb begin
		if (ch.bc0_hit) begin
			ch.allow = 1'b0;
		end else if (ch.mode_ext) begin
			ch.allow = 1'b1;
		end else if (ch.mode_self) begin
			ch.allow = ch.in_window;
		end else begin
			ch.allow = 1'b0;
		end
	end
endmodule : fbs_access_check

/* core/fbs_top.sv */
// Purpose: boot swap address translation and shield window gate for a flash array
// Assumes: all inputs come from logic on mclk_in; swap_nv_in mirrors the stored swap flag
// Notes: swap changes only take hold after a reset, so a half rewritten cluster never runs
`timescale 1ns/10ps
`include "fbs_params.svh"
module fbs_top (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic mode_self_in,
	input wire logic mode_ext_in,
	input wire logic bc0_protect_in,
	input wire logic win_wr_in,
	input wire logic [5:0] win_start_in,
	input wire logic [5:0] win_end_in,
	input wire logic swap_nv_in,
	input wire logic swap_set_in,
	input wire logic swap_clr_in,
	input wire logic [19:0] fetch_addr_in,
	input wire logic req_valid_in,
	input wire fbs_pkg::fbs_op_t req_op_in,
	input wire logic [19:0] req_addr_in,
	input wire logic err_clr_in,
	output logic boot_ready_out,
	output logic swap_active_out,
	output logic swap_nv_out,
	output logic [5:0] win_start_out,
	output logic [5:0] win_end_out,
	output logic [19:0] fetch_addr_out,
	output logic acc_valid_out,
	output fbs_pkg::fbs_op_t acc_op_out,
	output logic [19:0] acc_addr_out,
	output logic rej_out,
	output logic err_flag_out
);
	fbs_pkg::fbs_state_t state_reg;
	logic swap_act_reg;
	logic swap_nv_reg;
	logic [5:0] win_start_reg;
	logic [5:0] win_end_reg;
	logic [19:0] fetch_addr_reg;
	logic acc_valid_reg;
	fbs_pkg::fbs_op_t acc_op_reg;
	logic [19:0] acc_addr_reg;
	logic rej_reg;
	logic err_flag_reg;
	logic running;
	logic win_upd;
	logic [19:0] req_phys;

	fbs_chk_if ch ();

	// flip bit 12 inside the lowest 8 KB when the swap is active
	function automatic logic [19:0] fbs_xlate(input logic [19:0] a, input logic sw);
		logic [19:0] r;
		r = a;
		if (sw && (a[`FBS_ADDR_W-1:`FBS_SWAP_TOP_LSB] == `FBS_SWAP_TOP_ZERO)) begin
			r[`FBS_CLUS_BIT] = ~a[`FBS_CLUS_BIT];
		end
		return r;
	endfunction : fbs_xlate

	assign running = (state_reg == fbs_pkg::FBS_ST_RUN);
	assign win_upd = running && win_wr_in && (mode_ext_in || mode_self_in);
	assign req_phys = fbs_xlate(req_addr_in, swap_act_reg);

	// question to the checker
	assign ch.addr = req_phys;
	assign ch.mode_self = mode_self_in;
	assign ch.mode_ext = mode_ext_in;
	assign ch.bc0_protect = bc0_protect_in;
	assign ch.win_start = win_start_reg;
	assign ch.win_end = win_end_reg;

	fbs_access_check u_check (
		.ch(ch)
	);

	// boot sequence: the stored flag is caught one cycle after reset release
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_reg <= fbs_pkg::FBS_ST_LOAD;
		end else begin
			unique case (state_reg)
				fbs_pkg::FBS_ST_LOAD: begin
					state_reg <= fbs_pkg::FBS_ST_RUN;
				end
				fbs_pkg::FBS_ST_RUN: begin
					state_reg <= fbs_pkg::FBS_ST_RUN;
				end
				default: begin
					state_reg <= fbs_pkg::FBS_ST_LOAD;
				end
			endcase
		end
	end

	// active swap is frozen between resets; commits only reach the stored flag
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			swap_act_reg <= `FBS_SWAP_RST;
		end else if (state_reg == fbs_pkg::FBS_ST_LOAD) begin
			swap_act_reg <= swap_nv_in;
		end
	end

	// stored flag mirror: set beats clear so a racing commit is kept
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			swap_nv_reg <= `FBS_SWAP_RST;
		end else if (state_reg == fbs_pkg::FBS_ST_LOAD) begin
			swap_nv_reg <= swap_nv_in;
		end else if (swap_set_in) begin
			swap_nv_reg <= 1'b1;
		end else if (swap_clr_in) begin
			swap_nv_reg <= 1'b0;
		end
	end

	// window bounds, writable in either programming mode
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			win_start_reg <= `FBS_WIN_START_RST;
			win_end_reg <= `FBS_WIN_END_RST;
		end else if (win_upd) begin
			win_start_reg <= win_start_in;
			win_end_reg <= win_end_in;
		end
	end

	// fetch translation, one cycle of latency
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			fetch_addr_reg <= 20'h00000;
		end else begin
			fetch_addr_reg <= fbs_xlate(fetch_addr_in, swap_act_reg);
		end
	end

	// verdict on each request; requests during boot load are refused
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			acc_valid_reg <= 1'b0;
			rej_reg <= 1'b0;
			acc_op_reg <= fbs_pkg::FBS_OP_ERASE;
			acc_addr_reg <= 20'h00000;
		end else begin
			acc_valid_reg <= req_valid_in && running && ch.allow;
			rej_reg <= req_valid_in && !(running && ch.allow);
			if (req_valid_in) begin
				acc_op_reg <= req_op_in;
				acc_addr_reg <= req_phys;
			end
		end
	end

	// sticky error: a refusal in the clear cycle still lands
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			err_flag_reg <= 1'b0;
		end else if (req_valid_in && !(running && ch.allow)) begin
			err_flag_reg <= 1'b1;
		end else if (err_clr_in) begin
			err_flag_reg <= 1'b0;
		end
	end

	assign boot_ready_out = running;
	assign swap_active_out = swap_act_reg;
	assign swap_nv_out = swap_nv_reg;
	assign win_start_out = win_start_reg;
	assign win_end_out = win_end_reg;
	assign fetch_addr_out = fetch_addr_reg;
	assign acc_valid_out = acc_valid_reg;
	assign acc_op_out = acc_op_reg;
	assign acc_addr_out = acc_addr_reg;
	assign rej_out = rej_reg;
	assign err_flag_out = err_flag_reg;

	// boot steps: reset, load cycle, then running with the stored flag in force
	sequence s_boot_load;
		rst_in ##1 !rst_in && (state_reg == fbs_pkg::FBS_ST_LOAD);
	endsequence

	a_swap_boot_load: assert property (@(posedge mclk_in) s_boot_load |=>
		(swap_act_reg == $past(swap_nv_in)) && running)
		else $error("swap state not taken from stored flag at boot");

	a_swap_run_frozen: assert property (@(posedge mclk_in) disable iff (rst_in)
		running && $past(running) |-> $stable(swap_act_reg))
		else $error("active swap changed without a reset");

	a_fetch_bit_flip: assert property (@(posedge mclk_in) disable iff (rst_in)
		swap_act_reg && (fetch_addr_in[19:13] == 7'h00) |=>
		fetch_addr_reg == {$past(fetch_addr_in[19:13]), ~$past(fetch_addr_in[12]), $past(fetch_addr_in[11:0])})
		else $error("swapped fetch did not invert bit 12");

	a_fetch_high_pass: assert property (@(posedge mclk_in) disable iff (rst_in)
		(fetch_addr_in[19:13] != 7'h00) |=> fetch_addr_reg == $past(fetch_addr_in))
		else $error("fetch above 8 KB was altered");

	a_win_update: assert property (@(posedge mclk_in) disable iff (rst_in)
		win_upd |=> (win_start_reg == $past(win_start_in)) && (win_end_reg == $past(win_end_in)))
		else $error("window bounds not updated");

	a_win_idle_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
		!win_upd |=> $stable(win_start_reg) && $stable(win_end_reg))
		else $error("window bounds moved without an update");

	a_self_outside: assert property (@(posedge mclk_in) disable iff (rst_in)
		req_valid_in && mode_self_in && !mode_ext_in && !ch.in_window |=> rej_out && !acc_valid_out)
		else $error("self programming passed outside the window");

	a_ext_open: assert property (@(posedge mclk_in) disable iff (rst_in)
		req_valid_in && running && mode_ext_in && !ch.bc0_hit |=> acc_valid_out && !rej_out)
		else $error("external programming was refused off cluster 0");

	a_bc0_first: assert property (@(posedge mclk_in) disable iff (rst_in)
		req_valid_in && bc0_protect_in && (req_phys <= 20'h00fff) |=> rej_out ##0 err_flag_out)
		else $error("protected cluster 0 access not rejected");

	a_example_win: assert property (@(posedge mclk_in) disable iff (rst_in)
		req_valid_in && running && mode_self_in && !mode_ext_in && !ch.bc0_hit &&
		(win_start_reg == 6'h04) && (win_end_reg == 6'h06) |=>
		acc_valid_out == (($past(req_phys) >= 20'h01000) && ($past(req_phys) <= 20'h01bff)))
		else $error("example window range not honoured");
endmodule : fbs_top

/* test/fbs_prog_model.sv */
// Purpose: far side model that issues erase and write requests
// Assumes: requests change at the falling edge of mclk_in
// Notes: idle address lines show the inverse of the last value so stale data never matches
`timescale 1ns/10ps
module fbs_prog_model (
	input wire logic mclk_in,
	output logic req_valid_out,
	output fbs_pkg::fbs_op_t req_op_out,
	output logic [19:0] req_addr_out
);
	// quiet lines at time zero
	initial begin
		req_valid_out = 1'h0;
		req_op_out = fbs_pkg::FBS_OP_ERASE;
		req_addr_out = 20'h00000;
	end
	// one request per cycle at most; back to back is legal
	task step(input logic v, input fbs_pkg::fbs_op_t op, input logic [19:0] a);
		@(negedge mclk_in);
		req_valid_out = v;
		req_op_out = op;
		req_addr_out = v ? a : ~req_addr_out;
	endtask : step
endmodule : fbs_prog_model

/* test/fbs_top_tb.sv */
// Purpose: self-checking bench for the boot swap and shield window gate
// Assumes: inputs change at the falling edge, outputs read one edge later
// Notes: a reference model of window, cluster 0 guard and swap judges every burst and window answer
`timescale 1ns/10ps
`define CHK(g, e) begin if ((g) !== (e)) begin \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); n_mismatch++; end n_tests++; end
module fbs_top_tb;
	logic mclk_in = 1'h0;
	logic rst_in = 1'h1;
	logic m_self = 1'h0, m_ext = 1'h0, prot = 1'h0, win_wr = 1'h0, nv = 1'h0;
	logic s_set = 1'h0, s_clr = 1'h0, e_clr = 1'h0, rv, rdy, s_act, nv_o, acc_v, rej, err;
	logic [5:0] ws = 6'h00, we = 6'h00, ws_o, we_o;
	logic [19:0] fa = 20'h00000, ra, fa_o, acc_a;
	fbs_pkg::fbs_op_t rop, acc_op;
	int n_mismatch = 0, n_tests = 0, m_ws = 0, m_we = 63, m_swap = 0;
	// 100 MHz clock
	always #5 mclk_in = ~mclk_in;
	fbs_prog_model i_fbs_prog_model (.mclk_in(mclk_in), .req_valid_out(rv), .req_op_out(rop), .req_addr_out(ra));
	fbs_top i_fbs_top (.mclk_in(mclk_in), .rst_in(rst_in), .mode_self_in(m_self), .mode_ext_in(m_ext),
		.bc0_protect_in(prot), .win_wr_in(win_wr), .win_start_in(ws), .win_end_in(we), .swap_nv_in(nv),
		.swap_set_in(s_set), .swap_clr_in(s_clr), .fetch_addr_in(fa), .req_valid_in(rv), .req_op_in(rop),
		.req_addr_in(ra), .err_clr_in(e_clr), .boot_ready_out(rdy), .swap_active_out(s_act), .swap_nv_out(nv_o),
		.win_start_out(ws_o), .win_end_out(we_o), .fetch_addr_out(fa_o), .acc_valid_out(acc_v),
		.acc_op_out(acc_op), .acc_addr_out(acc_a), .rej_out(rej), .err_flag_out(err));
	// swap flips bit 12 only in the lowest 8 KB
	function automatic logic [19:0] xlate(input logic [19:0] a);
		xlate = (m_swap != 0 && a[19:13] == 7'h00) ? a ^ 20'h01000 : a;
	endfunction : xlate
	// cluster 0 guard first, then external wins, then the inclusive window
	function automatic logic ok(input logic [19:0] a);
		logic [19:0] t;
		t = xlate(a);
		ok = !(prot && t <= 20'h00fff)
			&& (m_ext || (m_self && t < 20'h10000 && t[15:10] >= m_ws && t[15:10] <= m_we));
	endfunction : ok
	task wrap_up;
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up
	// reset with a given stored swap flag, then wait for the run state
	task do_reset(input logic f);
		int k;
		@(negedge mclk_in);
		rst_in = 1'h1;
		nv = f;
		repeat (16) @(negedge mclk_in);
		`CHK(we_o, 6'h3f)
		`CHK(ws_o, 6'h00)
		rst_in = 1'h0;
		m_swap = f;
		m_ws = 0;
		m_we = 63;
		k = 0;
		while (rdy !== 1'h1 && k < 8) begin
			@(negedge mclk_in);
			k++;
		end
		if (k == 8) begin
			n_mismatch++;
			wrap_up();
		end
		// the load cycle ends at the first edge, so ready shows at the first falling edge after it
		`CHK(k, 1)
		`CHK(s_act, f)
		`CHK(nv_o, f)
	endtask : do_reset
	// window update; ignored when no mode is active
	task win(input logic [5:0] s, input logic [5:0] e);
		@(negedge mclk_in);
		ws = s;
		we = e;
		win_wr = 1'h1;
		@(negedge mclk_in);
		win_wr = 1'h0;
		if (m_self || m_ext) begin
			m_ws = s;
			m_we = e;
		end
		`CHK(ws_o, 6'(m_ws))
		`CHK(we_o, 6'(m_we))
	endtask : win
	// back to back requests with random fetches; f[19] set means random address
	task burst(input int n, input logic [19:0] f);
		logic [19:0] a, pa, pf;
		logic pok;
		fbs_pkg::fbs_op_t op, pop;
		for (int i = 0; i <= n; i++) begin
			a = 20'($urandom) & (($urandom % 2) ? 20'h01fff : 20'h1ffff);
			if (!f[19]) a = f;
			op = fbs_pkg::fbs_op_t'($urandom % 2);
			i_fbs_prog_model.step(i < n, op, a);
			if (i > 0) begin
				`CHK(acc_v, pok)
				`CHK(rej, !pok)
				if (pok) `CHK(acc_a, xlate(pa))
				if (pok) `CHK(acc_op, pop)
				`CHK(fa_o, xlate(pf))
			end
			fa = 20'($urandom) & 20'h03fff;
			pf = fa;
			pa = a;
			pop = op;
			pok = ok(a);
		end
	endtask : burst
	// main sequence
	initial begin
		void'($urandom(31906));
		do_reset(1'h0);
		m_self = 1'h1;
		win(6'h04, 6'h06);
		burst(60, 20'h80000);
		prot = 1'h1;
		burst(60, 20'h80000);
		m_ext = 1'h1;
		burst(40, 20'h80000);
		win(6'($urandom), 6'($urandom));
		m_ext = 1'h0;
		burst(30, 20'h80000);
		m_self = 1'h0;
		burst(8, 20'h80000);
		win(6'h01, 6'h02);
		`CHK(err, 1'h1)
		e_clr = 1'h1;
		@(negedge mclk_in);
		e_clr = 1'h0;
		`CHK(err, 1'h0)
		// refusal and clear on one edge: the refusal must win
		i_fbs_prog_model.step(1'h1, fbs_pkg::FBS_OP_WRITE, 20'h01000);
		e_clr = 1'h1;
		i_fbs_prog_model.step(1'h0, fbs_pkg::FBS_OP_WRITE, 20'h01000);
		e_clr = 1'h0;
		`CHK(rej, 1'h1)
		`CHK(err, 1'h1)
		e_clr = 1'h1;
		@(negedge mclk_in);
		e_clr = 1'h0;
		`CHK(err, 1'h0)
		m_self = 1'h1;
		prot = 1'h0;
		win(6'h00, 6'h3f);
		burst(1, 20'h01000);
		s_set = 1'h1;
		@(negedge mclk_in);
		s_set = 1'h0;
		`CHK(nv_o, 1'h1)
		`CHK(s_act, 1'h0)
		do_reset(1'h1);
		prot = 1'h1;
		m_self = 1'h1;
		burst(60, 20'h80000);
		s_clr = 1'h1;
		@(negedge mclk_in);
		s_clr = 1'h0;
		`CHK(nv_o, 1'h0)
		`CHK(s_act, 1'h1)
		// commit and clear together: the commit is kept
		s_set = 1'h1;
		s_clr = 1'h1;
		@(negedge mclk_in);
		s_set = 1'h0;
		s_clr = 1'h0;
		`CHK(nv_o, 1'h1)
		`CHK(s_act, 1'h1)
		wrap_up();
	end
	// cut a hang short
	initial begin
		#200000;
		n_mismatch++;
		wrap_up();
	end
endmodule : fbs_top_tb
